// *** design/ldoc_pkg.sv ***
// Package with register map, field layout and types for the LDO control bank.
package ldoc_pkg;

   localparam logic [7:0] LDOC_IMAGING_LOW_ADDR = 8'h42;
   localparam logic [7:0] LDOC_PROCESSOR_ADDR = 8'h44;
   localparam logic [7:0] LDOC_IMAGING_LOW_RESET = 8'h04;
   localparam logic [7:0] LDOC_PROCESSOR_RESET = 8'h3c;

   localparam int LDOC_STATE_LSB = 0;
   localparam int LDOC_EXIT_LSB = 3;
   localparam int LDOC_FIELD_W = 3;
   localparam int LDOC_NUM_LDO = 2;
   localparam int LDOC_IDX_IMAGING_LOW = 0;
   localparam int LDOC_IDX_PROCESSOR = 1;

   localparam logic [2:0] LDOC_CODE_OFF = 3'h4;
   localparam logic [2:0] LDOC_CODE_LOW_POWER = 3'h5;
   localparam logic [2:0] LDOC_CODE_ACTIVE = 3'h6;

   // Writable part of one control register; bits 7:6 are not stored.
   typedef struct packed {
      logic [2:0] exit_state;
      logic [2:0] state;
   } ldoc_ctrl_t;

   // Drive lines towards one regulator's analog section.
   typedef struct packed {
      logic enable;
      logic low_power;
      logic discharge;
   } ldoc_drive_t;

   // Register access strobe group from the serial interface decoder.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ldoc_reg_req_t;

endpackage

// *** design/ldoc_regs.sv ***
// Control registers and state decode for two linear regulators.
`timescale 1ns/10ps

module ldoc_regs
   import ldoc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire ldoc_reg_req_t i_reg_req,
   input wire logic i_standby_exit_pin,
   output logic [7:0] o_reg_rdata,
   output ldoc_drive_t o_processor_regulator,
   output ldoc_drive_t o_imaging_low_regulator
);

   localparam logic [7:0] RESET_VAL [LDOC_NUM_LDO] =
      '{LDOC_IMAGING_LOW_RESET, LDOC_PROCESSOR_RESET};
   localparam logic [7:0] ADDR_VAL [LDOC_NUM_LDO] =
      '{LDOC_IMAGING_LOW_ADDR, LDOC_PROCESSOR_ADDR};

   ldoc_ctrl_t ctrl [LDOC_NUM_LDO];
   ldoc_ctrl_t next_ctrl [LDOC_NUM_LDO];
   ldoc_drive_t drive [LDOC_NUM_LDO];
   logic [7:0] next_rdata;
   logic exit_sync1;
   logic exit_sync2;
   logic exit_prev;
   logic exit_rise;

   // The pin is asynchronous; only the second stage and its delayed copy feed the edge detect.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         exit_sync1 <= 1'b0;
         exit_sync2 <= 1'b0;
         exit_prev <= 1'b0;
      end
      else
      begin
         exit_sync1 <= i_standby_exit_pin;
         exit_sync2 <= exit_sync1;
         exit_prev <= exit_sync2;
      end
   end

   assign exit_rise = exit_sync2 & ~exit_prev;

   genvar g;
   generate
      for (g = 0; g < LDOC_NUM_LDO; g++)
      begin : g_ldo
         logic hit_wr;
         assign hit_wr = i_reg_req.wr && (i_reg_req.addr == ADDR_VAL[g]);

         // A standby exit in the same cycle as a host write overrides the written
         // state field if the old exit field has bit 2 set, since the exit event is the later request.
         always_comb
         begin
            next_ctrl[g] = ctrl[g];
            if (hit_wr)
            begin
               next_ctrl[g] = i_reg_req.wdata[5:0];
            end
            if (exit_rise && ctrl[g].exit_state[2])
            begin
               next_ctrl[g].state = ctrl[g].exit_state;
            end
         end

         always_ff @(posedge i_clock)
         begin
            if (i_sys_rst)
            begin
               ctrl[g] <= RESET_VAL[g][5:0];
            end
            else
            begin
               ctrl[g] <= next_ctrl[g];
            end
         end

         // Reserved state codes 0 to 3 decode as off, the safe choice for a rail; code 7 decodes as active.
         always_comb
         begin
            drive[g].enable = ctrl[g].state[2]
               && (ctrl[g].state != LDOC_CODE_OFF);
            drive[g].low_power = (ctrl[g].state == LDOC_CODE_LOW_POWER);
            drive[g].discharge = ~drive[g].enable;
         end
      end
   endgenerate

   always_comb
   begin
      next_rdata = 8'h00;
      for (int i = 0; i < LDOC_NUM_LDO; i++)
      begin
         if (i_reg_req.addr == ADDR_VAL[i])
         begin
            next_rdata = {2'b00, ctrl[i]};
         end
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         o_reg_rdata <= 8'h00;
      end
      else if (i_reg_req.rd)
      begin
         o_reg_rdata <= next_rdata;
      end
   end

   assign o_processor_regulator = drive[LDOC_IDX_PROCESSOR];
   assign o_imaging_low_regulator = drive[LDOC_IDX_IMAGING_LOW];

   sequence s_pin_rise;
      !i_standby_exit_pin ##1 i_standby_exit_pin;
   endsequence

   sequence s_proc_wr;
      i_reg_req.wr && i_reg_req.addr == LDOC_PROCESSOR_ADDR;
   endsequence

   property p_reset_value;
      @(posedge i_clock) i_sys_rst |=>
         ctrl[LDOC_IDX_PROCESSOR] == LDOC_PROCESSOR_RESET[5:0]
         && ctrl[LDOC_IDX_IMAGING_LOW] == LDOC_IMAGING_LOW_RESET[5:0];
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("Control registers did not take reset values.");

   property p_pin_to_copy;
      @(posedge i_clock) disable iff (i_sys_rst)
         s_pin_rise |-> ##2 exit_rise;
   endproperty
   a_pin_to_copy: assert property (p_pin_to_copy)
      else $error("Standby exit pin edge not seen two cycles later.");

   property p_exit_copy;
      @(posedge i_clock) disable iff (i_sys_rst)
         exit_rise && ctrl[LDOC_IDX_PROCESSOR].exit_state[2] |=>
         ctrl[LDOC_IDX_PROCESSOR].state ==
         $past(ctrl[LDOC_IDX_PROCESSOR].exit_state);
   endproperty
   a_exit_copy: assert property (p_exit_copy)
      else $error("Exit state was not copied into state field.");

   property p_exit_nocopy;
      @(posedge i_clock) disable iff (i_sys_rst)
         exit_rise && !ctrl[LDOC_IDX_IMAGING_LOW].exit_state[2]
         && !i_reg_req.wr |=> $stable(ctrl[LDOC_IDX_IMAGING_LOW].state);
   endproperty
   a_exit_nocopy: assert property (p_exit_nocopy)
      else $error("Do-not-copy exit code changed the state field.");

   property p_proc_write;
      @(posedge i_clock) disable iff (i_sys_rst)
         s_proc_wr ##0 !exit_rise |=>
         ctrl[LDOC_IDX_PROCESSOR] == $past(i_reg_req.wdata[5:0]);
   endproperty
   a_proc_write: assert property (p_proc_write)
      else $error("Processor register write not stored.");

   property p_independent;
      @(posedge i_clock) disable iff (i_sys_rst)
         i_reg_req.wr && i_reg_req.addr == LDOC_IMAGING_LOW_ADDR
         && !exit_rise |=> $stable(ctrl[LDOC_IDX_PROCESSOR])
         && ctrl[LDOC_IDX_IMAGING_LOW] == $past(i_reg_req.wdata[5:0]);
   endproperty
   a_independent: assert property (p_independent)
      else $error("Imaging write disturbed processor register.");

   property p_decode;
      @(posedge i_clock) disable iff (i_sys_rst)
         ctrl[LDOC_IDX_PROCESSOR].state[2:1] == 2'b11 |->
         o_processor_regulator.enable && !o_processor_regulator.low_power
         && !o_processor_regulator.discharge;
   endproperty
   a_decode: assert property (p_decode)
      else $error("Active code did not decode as active.");

   property p_off_discharge;
      @(posedge i_clock) disable iff (i_sys_rst)
         ctrl[LDOC_IDX_IMAGING_LOW].state == LDOC_CODE_OFF |->
         o_imaging_low_regulator.discharge
         && !o_imaging_low_regulator.enable;
   endproperty
   a_off_discharge: assert property (p_off_discharge)
      else $error("Off regulator lacks active discharge.");

   property p_read_back;
      @(posedge i_clock) disable iff (i_sys_rst)
         i_reg_req.rd && i_reg_req.addr == LDOC_PROCESSOR_ADDR |=>
         o_reg_rdata[7:6] == 2'b00
         && o_reg_rdata[5:0] == $past(ctrl[LDOC_IDX_PROCESSOR]);
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("Read data wrong or reserved bits not zero.");

   property p_low_power;
      @(posedge i_clock) disable iff (i_sys_rst)
         ctrl[LDOC_IDX_IMAGING_LOW].state == LDOC_CODE_LOW_POWER |->
         o_imaging_low_regulator.enable
         && o_imaging_low_regulator.low_power
         && !o_imaging_low_regulator.discharge;
   endproperty
   a_low_power: assert property (p_low_power)
      else $error("Low power code did not decode as low power.");

   // Reserved codes 0 to 3 must never power the processor rail, whatever the host wrote.
   property p_reserved_off;
      @(posedge i_clock) disable iff (i_sys_rst)
         !ctrl[LDOC_IDX_PROCESSOR].state[2] |->
         !o_processor_regulator.enable
         && !o_processor_regulator.low_power
         && o_processor_regulator.discharge;
   endproperty
   a_reserved_off: assert property (p_reserved_off)
      else $error("Reserved state code did not decode as off.");

   property p_unmapped_read;
      @(posedge i_clock) disable iff (i_sys_rst)
         i_reg_req.rd && i_reg_req.addr != LDOC_PROCESSOR_ADDR
         && i_reg_req.addr != LDOC_IMAGING_LOW_ADDR |=>
         o_reg_rdata == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("Read of an unmapped address did not return zero.");

endmodule

// *** tb/ldoc_host.sv ***
// Host model that issues single-byte register writes and reads.
`timescale 1ns/10ps

module ldoc_host
   import ldoc_pkg::*;
(
   input wire logic i_clock,
   input wire logic [7:0] i_rdata,
   output ldoc_reg_req_t o_req
);
   initial o_req = '0;

   // Released address and data are inverted so stale values never match.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clock);
      o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
      @(posedge i_clock);
      o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: o_req.wdata};
      @(posedge i_clock);
      o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~o_req.wdata};
      @(posedge i_clock);
      #1 q = i_rdata;
   endtask
endmodule

// *** tb/ldo_state_control_regs_test.sv ***
// Self-checking bench for the regulator control register bank.
`timescale 1ns/10ps

module ldo_state_control_regs_test;
   import ldoc_pkg::*;
   logic i_clock;
   logic i_sys_rst;
   logic i_standby_exit_pin;
   ldoc_reg_req_t req;
   logic [7:0] rdata;
   ldoc_drive_t drv [2];
   logic [7:0] m [2];
   logic [7:0] addr_of [2];
   int n_errors;
   int check_count;
   int cycles;

   ldoc_regs dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_reg_req(req), .i_standby_exit_pin(i_standby_exit_pin),
      .o_reg_rdata(rdata), .o_processor_regulator(drv[1]),
      .o_imaging_low_regulator(drv[0]));
   ldoc_host host_u (.i_clock(i_clock), .i_rdata(rdata), .o_req(req));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] want_drive(input logic [2:0] c);
      return {5'h00, c >= 3'h5, c == 3'h5, c < 3'h5};
   endfunction

   task automatic check_all();
      logic [7:0] d;
      for (int i = 0; i < 2; i++)
      begin
         host_u.rd_reg(addr_of[i], d);
         check(d, m[i]);
         check({5'h00, drv[i]}, want_drive(m[i][2:0]));
      end
   endtask

   task automatic put(input int i, input logic [7:0] d);
      host_u.wr_reg(addr_of[i], d);
      m[i] = d & 8'h3f;
   endtask

   // The pin stays high across a later write, which must not be undone.
   task automatic pulse_exit();
      @(posedge i_clock);
      i_standby_exit_pin <= 1'b1;
      repeat (6) @(posedge i_clock);
      for (int i = 0; i < 2; i++)
         if (m[i][5:3] >= 3'h4)
            m[i][2:0] = m[i][5:3];
      check_all();
      put(1, 8'h35);
      check_all();
      @(posedge i_clock);
      i_standby_exit_pin <= 1'b0;
      repeat (3) @(posedge i_clock);
   endtask

   // The exit pulse reaches the register at the very edge that takes the
   // write: the write stores the whole field, then the old exit field, if
   // it is a copy code, overrides the state.
   task automatic exit_with_write(input int i, input logic [7:0] d);
      logic [7:0] old [2];
      old = m;
      @(posedge i_clock);
      i_standby_exit_pin <= 1'b1;
      @(posedge i_clock);
      put(i, d);
      for (int j = 0; j < 2; j++)
         if (old[j][5:3] >= 3'h4)
            m[j][2:0] = old[j][5:3];
      check_all();
      @(posedge i_clock);
      i_standby_exit_pin <= 1'b0;
      repeat (3) @(posedge i_clock);
   endtask

   // A second reset in mid-run must bring back the values of a fresh start.
   task automatic mid_reset();
      @(posedge i_clock);
      i_sys_rst <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      m = '{LDOC_IMAGING_LOW_RESET, LDOC_PROCESSOR_RESET};
   endtask

   task automatic final_report();
      if (n_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         final_report();
      end
   end

   initial
   begin
      logic [7:0] d;
      logic [7:0] q;
      i_sys_rst = 1'b1;
      i_standby_exit_pin = 1'b0;
      n_errors = 0;
      check_count = 0;
      cycles = 0;
      addr_of = '{LDOC_IMAGING_LOW_ADDR, LDOC_PROCESSOR_ADDR};
      m = '{LDOC_IMAGING_LOW_RESET, LDOC_PROCESSOR_RESET};
      void'($urandom(7));
      repeat (4) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      check_all();
      for (int c = 0; c < 16; c++)
      begin
         d = 8'($urandom);
         d[2:0] = 3'(c / 2);
         put(c % 2, d);
         check_all();
      end
      for (int e = 0; e < 8; e++)
      begin
         d = 8'($urandom);
         d[5:3] = 3'(e);
         put(1, d);
         d = 8'($urandom);
         d[5:3] = 3'(7 - e);
         put(0, d);
         pulse_exit();
      end
      // Bit 5 alternates per register so both copy and no-copy meet a write.
      for (int e = 0; e < 6; e++)
      begin
         d = 8'($urandom);
         d[5] = e[1];
         exit_with_write(e % 2, d);
      end
      for (int a = 0; a < 2; a++)
      begin
         host_u.wr_reg(8'(8'h43 + a * 2), 8'($urandom));
         host_u.rd_reg(8'(8'h43 + a * 2), q);
         check(q, 8'h00);
      end
      check_all();
      mid_reset();
      check_all();
      final_report();
   end
endmodule
